// >>> bench/dht_display_model.sv
// Display-side model: measures every line seen on the timing outputs.
// Assumes line_start_i pulses once per line, in the cycle of count zero.
`timescale 1ns/1ps

module dht_display_model (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_b_i,
	// Timing inputs from the block
	input  wire logic        crt_hsync_i,
	input  wire logic        crt_blank_i,
	input  wire logic        panel_hsync_i,
	input  wire logic        panel_blank_i,
	input  wire logic        active_i,
	input  wire logic        line_start_i,
	// Measured line: length, blank, sync, active
	output logic      [35:0] line_o,
	output logic             done_o,
	output logic             split_o
);
	logic [8:0] len_q;
	logic [8:0] blk_q;
	logic [8:0] syn_q;
	logic [8:0] act_q;
	logic [8:0] base;

	// Restart the counts at each line start
	assign base = line_start_i ? 9'h000 : 9'h1FF;

	// Count region clocks; report the finished line at the next start
	always @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			{len_q, blk_q, syn_q, act_q, line_o} <= '0;
			done_o <= 1'b0;
			split_o <= 1'b0;
		end else begin
			done_o <= line_start_i;
			if (line_start_i) line_o <= {len_q, blk_q, syn_q, act_q};
			len_q <= (len_q & base) + 9'h001;
			blk_q <= (blk_q & base) + 9'(crt_blank_i);
			syn_q <= (syn_q & base) + 9'(crt_hsync_i);
			act_q <= (act_q & base) + 9'(active_i);
			// Both displays must see one timing
			if (panel_hsync_i !== crt_hsync_i || panel_blank_i !== crt_blank_i) split_o <= 1'b1;
		end
	end
endmodule

// >>> bench/tb_top.sv
// Testbench for the horizontal timing block: registers and line shape.
// Assumes one character clock and the display model on the timing outputs.
`timescale 1ns/1ps

module tb_top;
	logic        ref_clk_i = 1'b0;
	logic        rst_b_i = 1'b0;
	logic [15:0] avs_address_i = 16'h0000;
	logic        avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0000_0000;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic        crt_hsync_o, crt_blank_o, panel_hsync_o, panel_blank_o;
	logic        display_active_o, line_start_o, line_done, split;
	logic [10:0] vcount_o;
	logic [35:0] line_meas;
	int          n_mismatch = 0;
	int          cmp_count = 0;
	logic [31:0] lfsr_q = 32'h7528;
	logic [31:0] rd_q[$];
	logic [35:0] ln_q[$];
	logic [15:0] offs[4] = '{dht_pkg::OFF_H_TOTAL_ACTIVE, dht_pkg::OFF_H_BLANK_EDGES,
		dht_pkg::OFF_H_SYNC_EDGES, dht_pkg::OFF_TIMING_CTRL};
	// Total, active, blank begin, blank stop, sync start, sync end
	// Totals exceed widths, blanking lasts four clocks or more
	logic [7:0]  cfg[3][6] = '{'{8'h13, 8'h0B, 8'h0C, 8'h12, 8'h0E, 8'h10},
		'{8'h1F, 8'h14, 8'h18, 8'h02, 8'h1E, 8'h00}, '{8'hFF, 8'hF0, 8'hF8, 8'hFF, 8'hFA, 8'hFC}};

	// Clock of 100 ns
	always #50 ref_clk_i = ~ref_clk_i;

	dht_timing u_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.crt_hsync_o(crt_hsync_o), .crt_blank_o(crt_blank_o), .panel_hsync_o(panel_hsync_o),
		.panel_blank_o(panel_blank_o), .display_active_o(display_active_o),
		.line_start_o(line_start_o), .vcount_o(vcount_o));

	dht_display_model u_disp (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .crt_hsync_i(crt_hsync_o),
		.crt_blank_i(crt_blank_o), .panel_hsync_i(panel_hsync_o), .panel_blank_i(panel_blank_o),
		.active_i(display_active_o), .line_start_i(line_start_o), .line_o(line_meas),
		.done_o(line_done), .split_o(split));

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Clocks from begin to end, wrapping at the line length
	function automatic logic [8:0] span(input int a, input int b, input int t);
		return 9'((b - a + t) % t);
	endfunction

	task automatic check(input logic [35:0] got, input logic [35:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// One Avalon-MM cycle, held until waitrequest is sampled low
	task automatic bus(input logic we, input logic [15:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= we;
		avs_read_i <= !we;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 50);
		if (n >= 50) check(36'h1, 36'h0, "bus hang");
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		bus(1'b0, a, 32'h0000_0000);
	endtask

	task automatic report_and_stop;
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Watch outputs and compare against the oldest note
	always @(posedge ref_clk_i) begin
		if (avs_read_i && avs_waitrequest_o === 1'b0 && rd_q.size() > 0) begin
			check(avs_readdata_o, rd_q.pop_front(), "read");
		end
		if (line_done === 1'b1 && ln_q.size() > 0) begin
			check(line_meas, ln_q.pop_front(), "line");
		end
	end

	// Watchdog
	initial begin
		repeat (30000) @(posedge ref_clk_i);
		n_mismatch++;
		report_and_stop();
	end

	initial begin
		int k;
		int n;
		int t;
		logic [10:0] v0;
		logic [10:0] vt;
		repeat (2) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		// Stored bits of each word; reserved and ignored bits drop
		for (k = 0; k < 4; k++) begin
			lfsr_q = lfsr_next(lfsr_q);
			bus(1'b1, offs[k], lfsr_q);
			rd(offs[k], lfsr_q & (k < 3 ? dht_pkg::H_FIELD_MASK : dht_pkg::CTRL_MASK));
		end
		// Unused words of the window and beyond it
		bus(1'b1, 16'h832C, 32'hFFFF_FFFF);
		rd(16'h832C, 32'h0000_0000);
		rd(16'h833C, 32'h0000_0000);
		rd(dht_pkg::OFF_TIMING_LAST, 32'h0000_0000);
		// Line shapes: the first wraps a two-line frame, the second is interlaced
		for (k = 0; k < 3; k++) begin
			vt = (k == 0) ? 11'h001 : 11'h7FF;
			bus(1'b1, dht_pkg::OFF_TIMING_CTRL, 32'h0000_0000);
			lfsr_q = lfsr_next(lfsr_q);
			bus(1'b1, offs[0], {5'h00, cfg[k][0], lfsr_q[2:0], 5'h00, cfg[k][1], lfsr_q[5:3]});
			bus(1'b1, offs[1], {5'h00, cfg[k][3], lfsr_q[8:6], 5'h00, cfg[k][2], lfsr_q[11:9]});
			bus(1'b1, offs[2], {5'h00, cfg[k][5], lfsr_q[14:12], 5'h00, cfg[k][4], 3'h7});
			bus(1'b1, offs[3], {5'h00, vt, 14'h0000, k == 1, 1'b1});
			@(posedge line_start_o);
			repeat (3) @(posedge ref_clk_i);
			v0 = vcount_o;
			t = int'(cfg[k][0]) + 1;
			repeat (2) ln_q.push_back({9'(t), span(cfg[k][2], cfg[k][3], t), span(cfg[k][4], cfg[k][5], t),
				9'(cfg[k][1]) + 9'h001});
			n = 0;
			while (ln_q.size() > 0 && n < 2000) begin
				@(posedge ref_clk_i);
				n++;
			end
			if (n >= 2000) check(36'h1, 36'h0, "line hang");
			check(36'(vcount_o), 36'((int'(v0) + (k == 1 ? 4 : 2)) % (int'(vt) + 1)), "vcount");
		end
		// Disabled block holds its outputs low
		bus(1'b1, dht_pkg::OFF_TIMING_CTRL, 32'h0000_0000);
		repeat (2) @(posedge ref_clk_i);
		check(36'({crt_hsync_o, crt_blank_o, display_active_o, line_start_o, vcount_o}), 36'h0, "disabled");
		check(36'(split), 36'h0, "panel copy");
		// Reset in mid-run clears the total and active word and the status
		rst_b_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		rd(dht_pkg::OFF_H_TOTAL_ACTIVE, 32'h0000_0000);
		rd(dht_pkg::OFF_TIMING_STATUS, 32'h0000_0000);
		// Let the watcher take the last read before the verdict
		@(posedge ref_clk_i);
		check(36'(rd_q.size()), 36'h0, "reads left");
		report_and_stop();
	end
endmodule

// >>> hdl/dht_pkg.sv
// Package of constants for the horizontal display timing block.
// Assumes a 32-bit Avalon-MM register bus with byte addresses and one clock.
package dht_pkg;

	// Register byte offsets inside the block address window
	localparam logic [15:0] OFF_H_TOTAL_ACTIVE = 16'h8330;
	localparam logic [15:0] OFF_H_BLANK_EDGES  = 16'h8334;
	localparam logic [15:0] OFF_H_SYNC_EDGES   = 16'h8338;
	localparam logic [15:0] OFF_TIMING_LAST    = 16'h834C;
	localparam logic [15:0] OFF_TIMING_CTRL    = 16'h8350;
	localparam logic [15:0] OFF_TIMING_STATUS  = 16'h8354;

	// Timing register field layout
	localparam int HI_FIELD_MSB = 26;
	localparam int HI_FIELD_LSB = 19;
	localparam int LO_FIELD_MSB = 10;
	localparam int LO_FIELD_LSB = 3;
	localparam int CHAR_PIXELS  = 8;

	// Bits that store a value; reserved and ignored bits read as zero
	localparam logic [31:0] H_FIELD_MASK = 32'h07F8_07F8;

	// Control register layout
	localparam int CTRL_ENABLE_BIT    = 0;
	localparam int CTRL_INTERLACE_BIT = 1;
	localparam int CTRL_VTOTAL_LSB    = 16;
	localparam int CTRL_VTOTAL_MSB    = 26;
	localparam logic [31:0] CTRL_MASK = 32'h07FF_0003;

	// Status register layout
	localparam int STAT_HCOUNT_LSB = 0;
	localparam int STAT_BLANK_BIT  = 8;
	localparam int STAT_SYNC_BIT   = 9;
	localparam int STAT_ACTIVE_BIT = 10;
	localparam int STAT_VCOUNT_LSB = 16;

	// Reset values
	localparam logic [31:0] REG_RESET  = 32'h0000_0000;
	localparam logic [7:0]  HCNT_RESET = 8'h00;
	localparam logic [10:0] VCNT_RESET = 11'h000;

	// Widths
	localparam int HCNT_W = 8;
	localparam int VCNT_W = 11;

endpackage

// >>> hdl/dht_timing.sv
// Horizontal display timing generator with its Avalon-MM register slave.
// Assumes ref_clk_i is the character clock (one tick per eight pixels) and
// that the bus master holds each request until it sees waitrequest low.
`timescale 1ns/1ps

module dht_timing (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_b_i,
	// Avalon-MM slave
	input  wire logic [15:0] avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	// CRT timing outputs
	output logic             crt_hsync_o,
	output logic             crt_blank_o,
	// Flat panel timing outputs
	output logic             panel_hsync_o,
	output logic             panel_blank_o,
	// Shared display state
	output logic             display_active_o,
	output logic             line_start_o,
	output logic      [10:0] vcount_o
);

	// Field extraction used for every timing register
	function automatic logic [7:0] hi_field(input logic [31:0] w);
		hi_field = w[dht_pkg::HI_FIELD_MSB:dht_pkg::HI_FIELD_LSB];
	endfunction

	function automatic logic [7:0] lo_field(input logic [31:0] w);
		lo_field = w[dht_pkg::LO_FIELD_MSB:dht_pkg::LO_FIELD_LSB];
	endfunction

	// Registers and state
	logic [31:0] h_total_active_q;
	logic [31:0] h_blank_edges_q;
	logic [31:0] h_sync_edges_q;
	logic [31:0] ctrl_q;
	logic [31:0] rdata_q;
	logic        wait_q;
	logic [7:0]  hcnt_q;
	logic [7:0]  hcnt_d;
	logic [10:0] vcnt_q;
	logic [10:0] vcnt_d;
	logic        blank_q;
	logic        blank_d;
	logic        sync_q;
	logic        sync_d;
	logic        active_q;
	logic        active_d;
	logic        lstart_q;
	logic        panel_sync_q;
	logic        panel_blank_q;

	// Bus decode
	wire         req       = avs_read_i | avs_write_i;
	wire         accept    = req & ~wait_q;
	wire         wr_go     = avs_write_i & ~wait_q;
	wire         sel_h1    = avs_address_i == dht_pkg::OFF_H_TOTAL_ACTIVE;
	wire         sel_h2    = avs_address_i == dht_pkg::OFF_H_BLANK_EDGES;
	wire         sel_h3    = avs_address_i == dht_pkg::OFF_H_SYNC_EDGES;
	wire         sel_ctrl  = avs_address_i == dht_pkg::OFF_TIMING_CTRL;
	wire         sel_stat  = avs_address_i == dht_pkg::OFF_TIMING_STATUS;
	wire [31:0]  wdata_h   = avs_writedata_i & dht_pkg::H_FIELD_MASK;

	// Programmed fields
	wire [7:0]   total_f   = hi_field(h_total_active_q);
	wire [7:0]   act_f     = lo_field(h_total_active_q);
	wire [7:0]   bstop_f   = hi_field(h_blank_edges_q);
	wire [7:0]   bbegin_f  = lo_field(h_blank_edges_q);
	wire [7:0]   send_f    = hi_field(h_sync_edges_q);
	wire [7:0]   sbegin_f  = lo_field(h_sync_edges_q);
	wire         en        = ctrl_q[dht_pkg::CTRL_ENABLE_BIT];
	wire         ilace     = ctrl_q[dht_pkg::CTRL_INTERLACE_BIT];
	wire [10:0]  vtotal_f  = ctrl_q[dht_pkg::CTRL_VTOTAL_MSB:dht_pkg::CTRL_VTOTAL_LSB];

	// Read data selection; unmapped words, and the vertical words in the window, read zero
	wire [31:0]  status_w  = {5'h00, vcnt_q, 5'h00, active_q, sync_q, blank_q, hcnt_q};
	wire [31:0]  rd_sel    = sel_h1   ? h_total_active_q :
	                         sel_h2   ? h_blank_edges_q  :
	                         sel_h3   ? h_sync_edges_q   :
	                         sel_ctrl ? ctrl_q           :
	                         sel_stat ? status_w         : 32'h0000_0000;

	// One wait state: waitrequest drops one cycle after a request appears
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wait_q  <= 1'b1;
			rdata_q <= dht_pkg::REG_RESET;
		end else begin
			wait_q  <= ~(req & wait_q);
			if (req & wait_q) begin
				rdata_q <= rd_sel;
			end
		end
	end

	// Register writes, storing only the field bits
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			h_total_active_q <= dht_pkg::REG_RESET;
			h_blank_edges_q  <= dht_pkg::REG_RESET;
			h_sync_edges_q   <= dht_pkg::REG_RESET;
			ctrl_q           <= dht_pkg::REG_RESET;
		end else if (wr_go) begin
			if (sel_h1) begin
				h_total_active_q <= wdata_h;
			end
			if (sel_h2) begin
				h_blank_edges_q <= wdata_h;
			end
			if (sel_h3) begin
				h_sync_edges_q <= wdata_h;
			end
			if (sel_ctrl) begin
				ctrl_q <= avs_writedata_i & dht_pkg::CTRL_MASK;
			end
		end
	end

	// Character counter next value; wraps after the line total
	wire         h_wrap    = hcnt_q == total_f;
	wire         half_hit  = hcnt_q == {1'b0, total_f[7:1]};
	wire         v_step    = en & (h_wrap | (ilace & half_hit));
	assign hcnt_d = !en ? dht_pkg::HCNT_RESET :
	                h_wrap ? dht_pkg::HCNT_RESET : hcnt_q + 8'h01;
	assign vcnt_d = !en ? dht_pkg::VCNT_RESET :
	                !v_step ? vcnt_q :
	                (vcnt_q >= vtotal_f) ? dht_pkg::VCNT_RESET : vcnt_q + 11'h001;

	// Region edges, computed for the count that is about to be shown
	assign blank_d  = !en ? 1'b0 :
	                  (hcnt_d == bbegin_f) ? 1'b1 :
	                  (hcnt_d == bstop_f) ? 1'b0 : blank_q;
	assign sync_d   = !en ? 1'b0 :
	                  (hcnt_d == sbegin_f) ? 1'b1 :
	                  (hcnt_d == send_f) ? 1'b0 : sync_q;
	assign active_d = en & (hcnt_d <= act_f);

	// Counters and region flags
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			hcnt_q   <= dht_pkg::HCNT_RESET;
			vcnt_q   <= dht_pkg::VCNT_RESET;
			blank_q  <= 1'b0;
			sync_q   <= 1'b0;
			active_q <= 1'b0;
			lstart_q <= 1'b0;
		end else begin
			hcnt_q   <= hcnt_d;
			vcnt_q   <= vcnt_d;
			blank_q  <= blank_d;
			sync_q   <= sync_d;
			active_q <= active_d;
			lstart_q <= en & h_wrap;
		end
	end

	// Panel copies share the same counter and fields as the CRT
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			panel_sync_q  <= 1'b0;
			panel_blank_q <= 1'b0;
		end else begin
			panel_sync_q  <= sync_d;
			panel_blank_q <= blank_d;
		end
	end

	// Outputs straight from flip-flops
	assign avs_readdata_o    = rdata_q;
	assign avs_waitrequest_o = wait_q;
	assign crt_hsync_o       = sync_q;
	assign crt_blank_o       = blank_q;
	assign panel_hsync_o     = panel_sync_q;
	assign panel_blank_o     = panel_blank_q;
	assign display_active_o  = active_q;
	assign line_start_o      = lstart_q;
	assign vcount_o          = vcnt_q;

	// Checks on the timing and the bus
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	chk_counter_wrap: assert property (
		(en && h_wrap) |=> (hcnt_q == 8'h00))
		else $error("character counter did not restart after line total");

	chk_counter_step: assert property (
		(en && !h_wrap && !wr_go) |=> (hcnt_q == $past(hcnt_q) + 8'h01))
		else $error("character counter did not advance by one");

	chk_blank_begin: assert property (
		(en && hcnt_d == bbegin_f) |=> (crt_blank_o && panel_blank_o))
		else $error("blanking not active at blank start count");

	chk_blank_stop: assert property (
		(en && hcnt_d == bstop_f && hcnt_d != bbegin_f) |=> !crt_blank_o)
		else $error("blanking still active at blank end count");

	chk_sync_edges: assert property (
		(en && hcnt_d == sbegin_f) |=> crt_hsync_o ##0 (crt_hsync_o || hcnt_q == send_f))
		else $error("sync not active at sync start count");

	chk_sync_end: assert property (
		(en && hcnt_d == send_f && hcnt_d != sbegin_f) |=> !crt_hsync_o)
		else $error("sync still active at sync end count");

	chk_active_region: assert property (
		(en && !(wr_go && sel_h1)) |=> (display_active_o == (hcnt_q <= act_f)))
		else $error("active region disagrees with active width");

	chk_interlace_step: assert property (
		(ilace && v_step && vcnt_q < vtotal_f && !wr_go) |=> (vcnt_q == $past(vcnt_q) + 11'h001))
		else $error("vertical counter missed an interlace step");

	chk_shared_outputs: assert property (
		(crt_hsync_o == panel_hsync_o) && (crt_blank_o == panel_blank_o))
		else $error("CRT and panel timing diverged");

	chk_ignored_bits: assert property (
		(!avs_waitrequest_o) |-> (avs_readdata_o[18:16] == 3'h0 || sel_stat || sel_ctrl))
		else $error("ignored bits read back non-zero");

	chk_write_store: assert property (
		(wr_go && sel_h1) |=> (h_total_active_q == ($past(avs_writedata_i) & dht_pkg::H_FIELD_MASK)))
		else $error("timing register write not stored");

	chk_bus_answer: assert property (
		(req && wait_q) |=> !avs_waitrequest_o)
		else $error("waitrequest did not drop one cycle after request");

	// Further bus checks: single wait state, stored fields, unmapped words
	chk_wait_single: assert property (
		(!avs_waitrequest_o) |=> avs_waitrequest_o)
		else $error("waitrequest stayed low for more than one cycle");

	chk_blank_store: assert property (
		(wr_go && sel_h2) |=> (h_blank_edges_q == ($past(avs_writedata_i) & dht_pkg::H_FIELD_MASK)))
		else $error("blank edge register write not stored");

	chk_sync_store: assert property (
		(wr_go && sel_h3) |=> (h_sync_edges_q == ($past(avs_writedata_i) & dht_pkg::H_FIELD_MASK)))
		else $error("sync edge register write not stored");

	chk_ctrl_store: assert property (
		(wr_go && sel_ctrl) |=> (ctrl_q == ($past(avs_writedata_i) & dht_pkg::CTRL_MASK)))
		else $error("control register write not stored");

	chk_unmapped_zero: assert property (
		(avs_read_i && wait_q && !(sel_h1 || sel_h2 || sel_h3 || sel_ctrl || sel_stat))
		|=> (avs_readdata_o == 32'h0000_0000))
		else $error("unmapped word did not read zero");

	// Line boundary, vertical counter and disabled-output checks
	chk_line_pulse: assert property (
		(en && h_wrap) |=> line_start_o)
		else $error("line start pulse missing after line total");

	chk_line_only: assert property (
		line_start_o |-> (hcnt_q == dht_pkg::HCNT_RESET))
		else $error("line start pulse away from count zero");

	chk_vcount_hold: assert property (
		(en && !v_step) |=> (vcnt_q == $past(vcnt_q)))
		else $error("vertical counter moved between its step points");

	chk_vcount_wrap: assert property (
		(v_step && vcnt_q >= vtotal_f) |=> (vcnt_q == dht_pkg::VCNT_RESET))
		else $error("vertical counter did not restart after vertical total");

	chk_disabled_quiet: assert property (
		(!en) |=> (!crt_blank_o && !crt_hsync_o && !display_active_o && hcnt_q == dht_pkg::HCNT_RESET))
		else $error("disabled block left timing outputs active");

	// Main scenarios
	cov_line_wrap:   cover property (en && h_wrap ##1 en && hcnt_q == 8'h00);
	cov_blank_sync:  cover property (crt_blank_o && crt_hsync_o);
	cov_interlace:   cover property (ilace && v_step && half_hit && !h_wrap);
	cov_bus_read:    cover property (avs_read_i && !avs_waitrequest_o && sel_stat);
	cov_vcount_wrap: cover property (v_step && vcnt_q >= vtotal_f);

endmodule
